// *** inc/can_wake_pkg.sv ***
// Purpose: Shared constants for the CAN selective wake filter.
// Assumes: Wishbone classic, 32-bit data, byte addresses.
// Notes:   Offsets, field positions, reset values and timing figures.
package can_wake_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ID_OFS     = 8'h04;
  localparam logic [7:0] IDMASK_OFS = 8'h08;
  localparam logic [7:0] FRAME_OFS  = 8'h0c;
  localparam logic [7:0] DMLO_OFS   = 8'h10;
  localparam logic [7:0] DMHI_OFS   = 8'h14;
  localparam logic [7:0] STAT_OFS   = 8'h18;
  localparam logic [7:0] EVT_OFS    = 8'h1c;
  // ==========================================================
  // Control register fields
  localparam int MODE_LSB      = 0;
  localparam int SHDN_LSB      = 2;
  localparam int SEL_EN_BIT    = 4;
  localparam int CFG_OK_BIT    = 5;
  localparam int FD_TOL_BIT    = 6;
  localparam int DATA_EVAL_BIT = 7;
  localparam int WAKE_EN_BIT   = 8;
  localparam int FAIL_EN_BIT   = 9;
  localparam logic [9:0] CTRL_RESET = 10'h080;
  // Frame register: dlc in [3:0], extended-id flag here
  localparam int EXT_ID_BIT = 31;
  // Status fields
  localparam int STUCK_BIT = 0;
  localparam int SUPPLY_BIT = 1;
  localparam int ERRCNT_LSB = 8;
  // Event fields, write one to clear
  localparam int WAKE_EVT_BIT = 0;
  localparam int FERR_EVT_BIT = 1;
  localparam int FAIL_EVT_BIT = 2;
  // ==========================================================
  // Mode codes and counter limit
  localparam logic [1:0] MODE_OFFLINE = 2'h0;
  localparam logic [1:0] MODE_ACTIVE  = 2'h1;
  localparam logic [1:0] MODE_ACT_NUV = 2'h2;
  localparam logic [5:0] ERR_LIMIT    = 6'h1f;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ          = 100;
  localparam int DOM_TIMEOUT_US   = 1000;
  localparam int DOM_TIMEOUT_CYC  = DOM_TIMEOUT_US * CLK_MHZ;
  typedef enum logic [1:0] {
    SCAN_IDLE     = 2'b00,
    SCAN_LISTEN   = 2'b01,
    SCAN_WAIT_SOF = 2'b10,
    SCAN_WAIT_IDL = 2'b11
  } scan_state_t;
endpackage

// *** rtl/can_wake_filter.sv ***
// Purpose: Selective wake filter and fail-safe logic of a CAN transceiver.
// Assumes: A frame decoder delivers per-frame results as pulses.
// Notes:   Registers on Wishbone classic, one-cycle ack.
//
// Notes on behaviour
// - ID match plus good CRC wakes, no data check
// - Data check: ID, not remote, DLC, data, CRC
// - Pre-ack frame error increments error counter
// - Clean frame decrements error counter
// - Ignore bus after CRC delimiter until SOF
// - Counter above 31 sets error flag, wakes
// - Counter cleared on bias off and re-enable
// - Config writes clear the config-valid bit
// - Standard pattern wakes when filter inactive
// - Non-offline mode or wake disabled ignores patterns
// - FD tolerance: FD control field decrements counter
// - FD frames never wake
// - After FD control field ignore until idle
// - Without FD tolerance FD frames increment counter
// - Active mode: long low tx disables transmitter
// - Tx high resets dominant timer
// - Dominant time-out readable as status bit
// - Supply low or stuck tx sets failure irq
// - Battery irqs shut transceiver down per select
// - Select 00 never, 01 under, 10 over, 11 both
// - Wake sets wake irq, drives rx low
// - Mask bit one makes ID bit don't-care
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
module can_wake_filter #(
  parameter int DOM_TIMEOUT_CYCLES = can_wake_pkg::DOM_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Frame decoder results
  input  wire logic        sof_i,
  input  wire logic        frame_end_i,
  input  wire logic        frame_error_i,
  input  wire logic        fd_ctrl_i,
  input  wire logic        bus_idle_i,
  input  wire logic [28:0] rx_id_i,
  input  wire logic        rx_ext_i,
  input  wire logic        rx_remote_i,
  input  wire logic [3:0]  rx_dlc_i,
  input  wire logic [63:0] rx_data_i,
  input  wire logic        rx_crc_ok_i,
  input  wire logic        std_wake_pattern_i,
  input  wire logic        bus_rx_i,
  // System state
  input  wire logic        normal_mode_i,
  input  wire logic        bias_off_i,
  input  wire logic        can_supply_low_i,
  input  wire logic        battery_undervoltage_irq_i,
  input  wire logic        battery_overvoltage_irq_i,
  // Local controller pins and transmitter
  input  wire logic        can_tx_input_i,
  output logic             can_rx_output_o,
  output logic             bus_tx_o,
  output logic             tx_enable_o,
  output logic             can_shutdown_o,
  output logic             wake_o
);
  // ==========================================================
  // Registers
  logic [9:0]  ctrl;
  logic [28:0] cfg_id;
  logic        cfg_ext;
  logic [28:0] cfg_idmask;
  logic [3:0]  cfg_dlc;
  logic [63:0] cfg_dmask;
  logic        can_wake_irq;
  logic        frame_error_wake_flag;
  logic        can_failure_irq;
  logic        tx_stuck_low_status;
  logic [5:0]  err_cnt;
  logic [31:0] dom_cnt;
  logic        fail_src_q;
  logic        sel_active_q;
  can_wake_pkg::scan_state_t scan_state;

  logic [1:0] can_mode_select;
  logic [1:0] can_shutdown_select;
  logic       selective_wake_enable;
  logic       selective_config_valid;
  logic       fd_tolerance_enable;
  logic       data_eval_enable;
  logic       can_wake_enable;
  logic       can_failure_irq_enable;
  assign can_mode_select        = ctrl[can_wake_pkg::MODE_LSB +: 2];
  assign can_shutdown_select    = ctrl[can_wake_pkg::SHDN_LSB +: 2];
  assign selective_wake_enable  = ctrl[can_wake_pkg::SEL_EN_BIT];
  assign selective_config_valid = ctrl[can_wake_pkg::CFG_OK_BIT];
  assign fd_tolerance_enable    = ctrl[can_wake_pkg::FD_TOL_BIT];
  assign data_eval_enable       = ctrl[can_wake_pkg::DATA_EVAL_BIT];
  assign can_wake_enable        = ctrl[can_wake_pkg::WAKE_EN_BIT];
  assign can_failure_irq_enable = ctrl[can_wake_pkg::FAIL_EN_BIT];

  // ==========================================================
  // Bus decode
  logic wb_req;
  logic wb_wr;
  logic cfg_write;
  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr  = wb_req && we_i;
  // Any write to the filter setup invalidates it
  assign cfg_write = wb_wr && (adr_i >= can_wake_pkg::ID_OFS) &&
                     (adr_i <= can_wake_pkg::DMHI_OFS);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wb_req;
    end
  end

  // ==========================================================
  // Mode and state classification
  logic offline;
  logic wake_allowed;
  logic sel_active;
  logic tx_active;
  assign offline      = (can_mode_select == can_wake_pkg::MODE_OFFLINE);
  assign wake_allowed = offline && can_wake_enable;
  assign sel_active   = wake_allowed && selective_wake_enable &&
                        selective_config_valid;
  assign tx_active    = normal_mode_i &&
                        (can_mode_select == can_wake_pkg::MODE_ACTIVE ||
                         can_mode_select == can_wake_pkg::MODE_ACT_NUV);

  // ==========================================================
  // Per-frame evaluation
  logic        id_match;
  logic        data_match;
  logic [63:0] byte_sel;
  logic        frame_valid;
  logic        good_frame;
  always_comb begin
    logic [28:0] care;
    care = ~cfg_idmask;
    if (!cfg_ext) care[28:11] = 18'h0;
    id_match = (rx_ext_i == cfg_ext) &&
               (((rx_id_i ^ cfg_id) & care) == 29'h0);
    for (int b = 0; b < 8; b++)
      byte_sel[8*b +: 8] = (b < int'(rx_dlc_i)) ? 8'hff : 8'h00;
    data_match = (rx_dlc_i == 4'h0) ||
                 ((rx_data_i & cfg_dmask & byte_sel) != 64'h0);
  end
  // Errors before the ack field already count as bad frames
  assign good_frame  = rx_crc_ok_i && !frame_error_i;
  assign frame_valid = good_frame && id_match &&
                       (!data_eval_enable ||
                        (!rx_remote_i && rx_dlc_i == cfg_dlc &&
                         data_match));

  // ==========================================================
  // Frame scanner
  logic ev_err;
  logic ev_ok;
  logic ev_wake;
  logic sel_rise;
  assign sel_rise = sel_active && !sel_active_q;
  always_comb begin
    ev_err  = 1'b0;
    ev_ok   = 1'b0;
    ev_wake = 1'b0;
    if (sel_active && scan_state == can_wake_pkg::SCAN_LISTEN) begin
      if (fd_ctrl_i) begin
        // An FD frame never reaches the match logic
        ev_ok  = fd_tolerance_enable;
        ev_err = !fd_tolerance_enable;
      end else if (frame_end_i) begin
        ev_err  = !good_frame;
        ev_ok   = good_frame;
        ev_wake = frame_valid;
      end else if (frame_error_i) begin
        ev_err = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scan_state <= can_wake_pkg::SCAN_IDLE;
    end else if (!sel_active) begin
      scan_state <= can_wake_pkg::SCAN_IDLE;
    end else begin
      unique case (scan_state)
        can_wake_pkg::SCAN_IDLE,
        can_wake_pkg::SCAN_WAIT_SOF: begin
          if (sof_i) scan_state <= can_wake_pkg::SCAN_LISTEN;
        end
        can_wake_pkg::SCAN_LISTEN: begin
          if (fd_ctrl_i)
            scan_state <= can_wake_pkg::SCAN_WAIT_IDL;
          else if (frame_end_i || frame_error_i)
            scan_state <= can_wake_pkg::SCAN_WAIT_SOF;
        end
        can_wake_pkg::SCAN_WAIT_IDL: begin
          if (bus_idle_i)
            scan_state <= can_wake_pkg::SCAN_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Frame error counter
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_active_q <= 1'b0;
      err_cnt      <= 6'h00;
    end else begin
      sel_active_q <= sel_active;
      if (sel_rise && bias_off_i)
        err_cnt <= 6'h00;
      else if (ev_err && err_cnt <= can_wake_pkg::ERR_LIMIT)
        err_cnt <= err_cnt + 6'h01;
      else if (ev_ok && err_cnt != 6'h00)
        err_cnt <= err_cnt - 6'h01;
    end
  end

  // ==========================================================
  // Wake flags; a set in the clearing cycle wins
  logic std_wake;
  logic ferr_set;
  logic evt_clr_wr;
  assign std_wake   = std_wake_pattern_i && wake_allowed &&
                      !(selective_wake_enable &&
                        selective_config_valid);
  assign ferr_set   = sel_active &&
                      err_cnt > can_wake_pkg::ERR_LIMIT;
  assign evt_clr_wr = wb_wr && adr_i == can_wake_pkg::EVT_OFS && sel_i[0];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      can_wake_irq <= 1'b0;
    end else if (ev_wake || std_wake) begin
      can_wake_irq <= 1'b1;
    end else if (evt_clr_wr && dat_i[can_wake_pkg::WAKE_EVT_BIT]) begin
      can_wake_irq <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_error_wake_flag <= 1'b0;
    end else if (ferr_set) begin
      frame_error_wake_flag <= 1'b1;
    end else if (evt_clr_wr && dat_i[can_wake_pkg::FERR_EVT_BIT]) begin
      frame_error_wake_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit dominant time-out
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dom_cnt             <= 32'h0;
      tx_stuck_low_status <= 1'b0;
    end else if (can_tx_input_i) begin
      dom_cnt             <= 32'h0;
      tx_stuck_low_status <= 1'b0;
    end else if (tx_active && !tx_stuck_low_status) begin
      // Bounds the dominant run; slow controllers would trip it
      if (dom_cnt >= 32'(DOM_TIMEOUT_CYCLES - 1))
        tx_stuck_low_status <= 1'b1;
      else
        dom_cnt <= dom_cnt + 32'h1;
    end
  end

  // ==========================================================
  // Failure interrupt on rising status
  logic fail_src;
  assign fail_src = can_supply_low_i || tx_stuck_low_status;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fail_src_q      <= 1'b0;
      can_failure_irq <= 1'b0;
    end else begin
      fail_src_q <= fail_src;
      if (fail_src && !fail_src_q && can_failure_irq_enable)
        can_failure_irq <= 1'b1;
      else if (evt_clr_wr && dat_i[can_wake_pkg::FAIL_EVT_BIT])
        can_failure_irq <= 1'b0;
    end
  end

  // ==========================================================
  // Pin outputs
  logic shut_now;
  assign shut_now = normal_mode_i &&
                    ((can_shutdown_select[0] && battery_undervoltage_irq_i) ||
                     (can_shutdown_select[1] && battery_overvoltage_irq_i));
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      can_rx_output_o <= 1'b1;
      bus_tx_o        <= 1'b1;
      tx_enable_o     <= 1'b0;
      can_shutdown_o  <= 1'b0;
      wake_o          <= 1'b0;
    end else begin
      can_shutdown_o  <= shut_now;
      // Rx stays low while a wake is pending in low power
      can_rx_output_o <= tx_active ? bus_rx_i : !can_wake_irq;
      tx_enable_o     <= tx_active && !tx_stuck_low_status &&
                         !shut_now;
      bus_tx_o        <= can_tx_input_i || tx_stuck_low_status ||
                         !tx_active;
      wake_o          <= can_wake_irq || frame_error_wake_flag;
    end
  end

  // ==========================================================
  // Register writes and reads
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl       <= can_wake_pkg::CTRL_RESET;
      cfg_id     <= 29'h0;
      cfg_ext    <= 1'b0;
      cfg_idmask <= 29'h0;
      cfg_dlc    <= 4'h0;
      cfg_dmask  <= 64'h0;
    end else begin
      if (cfg_write)
        ctrl[can_wake_pkg::CFG_OK_BIT] <= 1'b0;
      if (wb_wr) begin
        unique case (adr_i)
          can_wake_pkg::CTRL_OFS:
            ctrl <= 10'(merge({22'h0, ctrl}, dat_i, sel_i));
          can_wake_pkg::ID_OFS: begin
            cfg_id <= 29'(merge({3'h0, cfg_id}, dat_i, sel_i));
          end
          can_wake_pkg::IDMASK_OFS:
            cfg_idmask <= 29'(merge({3'h0, cfg_idmask}, dat_i, sel_i));
          can_wake_pkg::FRAME_OFS: begin
            if (sel_i[0]) cfg_dlc <= dat_i[3:0];
            if (sel_i[3]) cfg_ext <= dat_i[can_wake_pkg::EXT_ID_BIT];
          end
          can_wake_pkg::DMLO_OFS:
            cfg_dmask[31:0] <= merge(cfg_dmask[31:0], dat_i, sel_i);
          can_wake_pkg::DMHI_OFS:
            cfg_dmask[63:32] <= merge(cfg_dmask[63:32], dat_i, sel_i);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (wb_req && !we_i) begin
      unique case (adr_i)
        can_wake_pkg::CTRL_OFS:   dat_o <= {22'h0, ctrl};
        can_wake_pkg::ID_OFS:     dat_o <= {3'h0, cfg_id};
        can_wake_pkg::IDMASK_OFS: dat_o <= {3'h0, cfg_idmask};
        can_wake_pkg::FRAME_OFS:  dat_o <= {cfg_ext, 27'h0, cfg_dlc};
        can_wake_pkg::DMLO_OFS:   dat_o <= cfg_dmask[31:0];
        can_wake_pkg::DMHI_OFS:   dat_o <= cfg_dmask[63:32];
        can_wake_pkg::STAT_OFS:
          dat_o <= {18'h0, err_cnt, 6'h0, can_supply_low_i,
                    tx_stuck_low_status};
        can_wake_pkg::EVT_OFS:
          dat_o <= {29'h0, can_failure_irq, frame_error_wake_flag,
                    can_wake_irq};
        default: dat_o <= 32'h0;
      endcase
    end else begin
      dat_o <= 32'h0;
    end
  end
endmodule

// *** verif/can_frame_source.sv ***
// Purpose: Model of the bus side: frame decoder results and wake patterns.
// Assumes: Results are pulses one cycle wide, launched after a clock edge.
// Notes:   Fields are scrambled when no frame result is being shown.
`timescale 1ns/1ns
module can_frame_source (
  // Clock
  input  wire logic        ref_clk_i,
  // Decoder results
  output logic             sof_o = 1'b0,
  output logic             frame_end_o = 1'b0,
  output logic             frame_error_o = 1'b0,
  output logic             fd_ctrl_o = 1'b0,
  output logic             bus_idle_o = 1'b1,
  output logic [28:0]      rx_id_o = 29'h0,
  output logic             rx_ext_o = 1'b0,
  output logic             rx_remote_o = 1'b0,
  output logic [3:0]       rx_dlc_o = 4'h0,
  output logic [63:0]      rx_data_o = 64'h0,
  output logic             rx_crc_ok_o = 1'b0,
  output logic             std_wake_pattern_o = 1'b0,
  output logic             bus_rx_o = 1'b1
);
  // Kind 0 good, 1 error, 2 fd control field, 3 bad crc
  task automatic send(input logic [1:0] kind, input logic [28:0] id,
                      input logic rem, input logic [3:0] dlc,
                      input logic [63:0] dat);
    @(posedge ref_clk_i);
    bus_idle_o <= 1'b0;
    bus_rx_o   <= 1'b0;
    sof_o      <= 1'b1;
    @(posedge ref_clk_i);
    sof_o <= 1'b0;
    @(posedge ref_clk_i);
    rx_id_o       <= id;
    rx_remote_o   <= rem;
    rx_dlc_o      <= dlc;
    rx_data_o     <= dat;
    rx_crc_ok_o   <= kind != 2'h3;
    frame_end_o   <= kind == 2'h0 || kind == 2'h3;
    frame_error_o <= kind == 2'h1;
    fd_ctrl_o     <= kind == 2'h2;
    @(posedge ref_clk_i);
    // Stray result before idle or next start must be ignored
    frame_end_o   <= kind != 2'h0;
    frame_error_o <= kind == 2'h0;
    fd_ctrl_o     <= 1'b0;
    rx_crc_ok_o   <= 1'b1;
    @(posedge ref_clk_i);
    frame_end_o   <= 1'b0;
    frame_error_o <= 1'b0;
    rx_id_o       <= ~id;
    rx_remote_o   <= ~rem;
    rx_dlc_o      <= ~dlc;
    rx_data_o     <= ~dat;
    rx_crc_ok_o   <= 1'b0;
    bus_rx_o      <= 1'b1;
    bus_idle_o    <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic wake();
    @(posedge ref_clk_i);
    std_wake_pattern_o <= 1'b1;
    @(posedge ref_clk_i);
    std_wake_pattern_o <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask
endmodule

// *** verif/can_wake_filter_assertions.sv ***
// Purpose: Port-level checks of the CAN selective wake filter.
// Assumes: One clock, reset active high and asynchronous.
// Notes:   Bound into every instance of the filter.
`timescale 1ns/1ns
module can_wake_filter_checker #(
  parameter int DOM_TIMEOUT_CYCLES = can_wake_pkg::DOM_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Transmitter and supervision
  input wire logic        normal_mode_i,
  input wire logic        battery_undervoltage_irq_i,
  input wire logic        battery_overvoltage_irq_i,
  input wire logic        can_tx_input_i,
  input wire logic        bus_tx_o,
  input wire logic        tx_enable_o,
  input wire logic        can_shutdown_o
);
  // Nothing else may disable the transmitter during a short low run
  wire logic quiet = normal_mode_i && !battery_undervoltage_irq_i &&
                     !battery_overvoltage_irq_i && !(cyc_i && stb_i && we_i);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Register bus
  property p_ack_follows;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("ack missing after request");
  property p_ack_once;
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack longer than one cycle");
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_idle;
    !ack_o |-> dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  // ==========================================================
  // Transmitter
  property p_tx_off;
    !normal_mode_i |=> !tx_enable_o && bus_tx_o;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("transmitter on outside active mode");
  property p_tx_pass;
    tx_enable_o |-> bus_tx_o == $past(can_tx_input_i);
  endproperty
  a_tx_pass: assert property (p_tx_pass)
    else $error("enabled transmitter not following tx input");
  sequence s_low_run;
    $fell(can_tx_input_i) && tx_enable_o && quiet
      ##1 (quiet && !can_tx_input_i)[*8];
  endsequence
  property p_no_early_trip;
    s_low_run |-> tx_enable_o;
  endproperty
  a_no_early_trip: assert property (p_no_early_trip)
    else $error("transmitter cut before time-out");
  property p_shdn_off;
    !normal_mode_i |=> !can_shutdown_o;
  endproperty
  a_shdn_off: assert property (p_shdn_off)
    else $error("shutdown outside normal mode");
endmodule
bind can_wake_filter can_wake_filter_checker #(
  .DOM_TIMEOUT_CYCLES(DOM_TIMEOUT_CYCLES)
) i_can_wake_filter_checker (
  .ref_clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o,
  .normal_mode_i, .battery_undervoltage_irq_i, .battery_overvoltage_irq_i,
  .can_tx_input_i, .bus_tx_o, .tx_enable_o, .can_shutdown_o
);

// *** verif/test_can_wake_filter.sv ***
// Purpose: Self-checking bench of the CAN selective wake filter.
// Assumes: Wishbone classic master, one idle cycle between requests.
// Notes:   Time-out shortened to DOM cycles.
`timescale 1ns/1ns
module test_can_wake_filter;
  localparam int DOM = 20;
  localparam logic [7:0] CT = can_wake_pkg::CTRL_OFS;
  localparam logic [7:0] ST = can_wake_pkg::STAT_OFS;
  localparam logic [7:0] EV = can_wake_pkg::EVT_OFS;
  localparam logic [3:0][9:0] SW = {10'h000, 10'h101, 10'h110, 10'h100};
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic        normal_mode_i = 1'b0, bias_off_i = 1'b0;
  logic        can_supply_low_i = 1'b0, can_tx_input_i = 1'b1;
  logic        battery_undervoltage_irq_i = 1'b0;
  logic        battery_overvoltage_irq_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o, can_rx_output_o, bus_tx_o, tx_enable_o;
  logic        can_shutdown_o, wake_o, sof_i, frame_end_i, frame_error_i;
  logic        fd_ctrl_i, bus_idle_i, rx_ext_i, rx_remote_i, rx_crc_ok_i;
  logic        std_wake_pattern_i, bus_rx_i;
  logic [28:0] rx_id_i;
  logic [3:0]  rx_dlc_i;
  logic [63:0] rx_data_i;
  int          err_total = 0, n_compared = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  can_wake_filter #(.DOM_TIMEOUT_CYCLES(DOM)) i_can_wake_filter (
    .ref_clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf),
    .dat_i, .dat_o, .ack_o, .sof_i, .frame_end_i, .frame_error_i,
    .fd_ctrl_i, .bus_idle_i, .rx_id_i, .rx_ext_i, .rx_remote_i, .rx_dlc_i,
    .rx_data_i, .rx_crc_ok_i, .std_wake_pattern_i, .bus_rx_i,
    .normal_mode_i, .bias_off_i, .can_supply_low_i,
    .battery_undervoltage_irq_i, .battery_overvoltage_irq_i,
    .can_tx_input_i, .can_rx_output_o, .bus_tx_o, .tx_enable_o,
    .can_shutdown_o, .wake_o);
  can_frame_source src (
    .ref_clk_i, .sof_o(sof_i), .frame_end_o(frame_end_i),
    .frame_error_o(frame_error_i), .fd_ctrl_o(fd_ctrl_i),
    .bus_idle_o(bus_idle_i), .rx_id_o(rx_id_i), .rx_ext_o(rx_ext_i),
    .rx_remote_o(rx_remote_i), .rx_dlc_o(rx_dlc_i), .rx_data_o(rx_data_i),
    .rx_crc_ok_o(rx_crc_ok_i), .std_wake_pattern_o(std_wake_pattern_i),
    .bus_rx_o(bus_rx_i));
  // ==========================================================
  // Tasks
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic chk_pin(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge ref_clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk_reg(q, e);
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(CT, 32'h80);
    rd(8'h40, 32'h0);
    wr(CT, 32'h1b0);
    wr(can_wake_pkg::ID_OFS, 32'h1a0);
    rd(CT, 32'h190);
    wr(can_wake_pkg::IDMASK_OFS, 32'h7);
    wr(can_wake_pkg::FRAME_OFS, 32'h1);
    wr(can_wake_pkg::DMLO_OFS, 32'ha8);
    wr(can_wake_pkg::DMHI_OFS, 32'h0);
    rd(CT, 32'h190);
    wr(CT, 32'h1b0);
    // Near misses first; the flag is sticky, so one look covers them all
    src.send(2'h0, 29'h1a5, 1'h1, 4'h1, 64'h08);
    src.send(2'h0, 29'h1a5, 1'h0, 4'h2, 64'h08);
    src.send(2'h0, 29'h1a5, 1'h0, 4'h1, 64'h54);
    src.send(2'h3, 29'h1a5, 1'h0, 4'h1, 64'h08);
    src.send(2'h0, 29'h1a8, 1'h0, 4'h1, 64'h08);
    chk_pin(wake_o, 1'b0);
    src.send(2'h0, 29'h1a2, 1'h0, 4'h1, 64'h08);
    chk_pin(wake_o, 1'b1);
    chk_pin(can_rx_output_o, 1'b0);
    rd(EV, 32'h1);
    wr(EV, 32'h7);
    @(posedge ref_clk_i);
    chk_pin(wake_o, 1'b0);
    wr(CT, 32'h130);
    src.send(2'h1, 29'h1a5, 1'h0, 4'h0, 64'h0);
    src.send(2'h2, 29'h1a5, 1'h0, 4'h0, 64'h0);
    wr(CT, 32'h170);
    src.send(2'h2, 29'h1a5, 1'h0, 4'h0, 64'h0);
    chk_pin(wake_o, 1'b0);
    src.send(2'h0, 29'h1a7, 1'h1, 4'h5, 64'h0);
    chk_pin(wake_o, 1'b1);
    wr(EV, 32'h7);
    // Error counter walk, from the floor up past the limit
    wr(CT, 32'h130);
    repeat (8) src.send(2'h0, 29'h0, 1'h0, 4'h0, 64'h0);
    rd(ST, 32'h0);
    repeat (3) src.send(2'h1, 29'h0, 1'h0, 4'h0, 64'h0);
    rd(ST, 32'h300);
    src.send(2'h0, 29'h0, 1'h0, 4'h0, 64'h0);
    rd(ST, 32'h200);
    wr(CT, 32'h170);
    src.send(2'h2, 29'h0, 1'h0, 4'h0, 64'h0);
    rd(ST, 32'h100);
    wr(CT, 32'h130);
    src.send(2'h2, 29'h0, 1'h0, 4'h0, 64'h0);
    rd(ST, 32'h200);
    repeat (29) src.send(2'h1, 29'h0, 1'h0, 4'h0, 64'h0);
    rd(ST, 32'h1f00);
    chk_pin(wake_o, 1'b0);
    src.send(2'h2, 29'h0, 1'h0, 4'h0, 64'h0);
    rd(ST, 32'h2000);
    chk_pin(wake_o, 1'b1);
    rd(EV, 32'h2);
    bias_off_i <= 1'b1;
    wr(CT, 32'h120);
    wr(CT, 32'h130);
    rd(ST, 32'h0);
    bias_off_i <= 1'b0;
    wr(EV, 32'h7);
    for (int i = 0; i < 4; i++) begin
      wr(CT, {22'h0, SW[i]});
      src.wake();
      chk_pin(wake_o, i < 2);
      wr(EV, 32'h7);
    end
    // Transmit supervision in active mode
    normal_mode_i <= 1'b1;
    wr(CT, 32'h201);
    can_tx_input_i <= 1'b0;
    repeat (DOM - 2) @(posedge ref_clk_i);
    can_tx_input_i <= 1'b1;
    rd(ST, 32'h0);
    can_tx_input_i <= 1'b0;
    repeat (DOM - 2) @(posedge ref_clk_i);
    chk_pin(tx_enable_o, 1'b1);
    repeat (6) @(posedge ref_clk_i);
    chk_pin(tx_enable_o, 1'b0);
    chk_pin(bus_tx_o, 1'b1);
    rd(ST, 32'h1);
    rd(EV, 32'h4);
    can_tx_input_i <= 1'b1;
    rd(ST, 32'h0);
    wr(EV, 32'h7);
    can_supply_low_i <= 1'b1;
    rd(ST, 32'h2);
    rd(EV, 32'h4);
    can_supply_low_i <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 3; k++) begin
        wr(CT, {28'h0, s[1:0], 2'h1});
        battery_undervoltage_irq_i <= k == 1;
        battery_overvoltage_irq_i  <= k == 2;
        repeat (3) @(posedge ref_clk_i);
        chk_pin(can_shutdown_o,
                (k == 1 && s[0]) || (k == 2 && s[1]));
      end
    end
    normal_mode_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    chk_pin(can_shutdown_o, 1'b0);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    tally_and_finish();
  end
endmodule
